/* aan_annunciator.sv */
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ns

module aan_annunciator #(
    parameter int NUM_PORTS = aan_pkg::NUM_PORTS,
    parameter int BEEP_HALF_CYC = aan_pkg::BEEP_HALF_CYC,
    parameter int BLINK_HALF_CYC = aan_pkg::BLINK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sensor evaluation side, same clock.
    input wire logic [3*NUM_PORTS-1:0] port_state,
    // Operator keypad and USB pins, asynchronous.
    input wire logic key_mute,
    input wire logic key_ack,
    input wire logic usb_connected,
    // Outputs.
    output logic [NUM_PORTS-1:0] lamp_red,
    output logic [NUM_PORTS-1:0] lamp_green,
    output logic usb_lamp,
    output logic beeper,
    output logic master_relay,
    output logic [NUM_PORTS-1:0] zone_relay,
    output logic irq
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic [1:0] key_prev_q;
    logic mute_pulse;
    logic ack_pulse;

    // Two stages before any logic looks at keypad or USB pins.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
            key_prev_q <= 2'h0;
        end
        else
        begin
            pin_meta_q <= {usb_connected, key_ack, key_mute};
            pin_sync_q <= pin_meta_q;
            key_prev_q <= pin_sync_q[1:0];
        end
    end

    // A press is acted on once, at its rising edge, however long it is held.
    assign mute_pulse = pin_sync_q[0] & ~key_prev_q[0];
    assign ack_pulse = pin_sync_q[1] & ~key_prev_q[1];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic [NUM_PORTS-1:0] zone_nc_q;
    logic [NUM_PORTS-1:0] zone_latch_q;
    logic [aan_pkg::IRQ_W-1:0] irq_stat_q;
    logic [aan_pkg::IRQ_W-1:0] irq_en_q;
    aan_pkg::aan_ahb_addr_t ap_q;
    logic ap_valid_q;
    logic wr_en;

    // Capture the address phase; every transfer completes with zero waits.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            ap_valid_q <= 1'b0;
            ap_q <= '0;
        end
        else if (hready)
        begin
            ap_valid_q <= hsel & htrans[1];
            ap_q <= '{htrans: htrans, hwrite: hwrite, hsize: hsize, haddr: haddr[7:0]};
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = ap_valid_q & ap_q.hwrite;

    // Software-writable configuration.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            ctrl_q <= aan_pkg::CTRL_RESET;
            zone_nc_q <= '0;
            zone_latch_q <= '0;
            irq_en_q <= '0;
        end
        else if (wr_en)
        begin
            case (ap_q.haddr)
                aan_pkg::ADDR_CTRL: ctrl_q <= hwdata[2:0];
                aan_pkg::ADDR_ZONE_NC: zone_nc_q <= hwdata[NUM_PORTS-1:0];
                aan_pkg::ADDR_ZONE_LATCH: zone_latch_q <= hwdata[NUM_PORTS-1:0];
                aan_pkg::ADDR_IRQ_EN: irq_en_q <= hwdata[aan_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Per-port decode and lamps
    // ------------------------------------------------------------------
    logic [NUM_PORTS-1:0] is_alarm;
    logic [NUM_PORTS-1:0] is_error;
    logic [NUM_PORTS-1:0] zone_act_q;
    logic blink_q;
    logic [aan_pkg::CNT_W-1:0] blink_cnt_q;

    // Free-running blink phase for the lamps.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end
        else if (blink_cnt_q == aan_pkg::CNT_W'(BLINK_HALF_CYC - 1))
        begin
            blink_cnt_q <= '0;
            blink_q <= ~blink_q;
        end
        else
        begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
        end
    end

    generate
        for (genvar i = 0; i < NUM_PORTS; i++)
        begin : g_port
            aan_pkg::aan_port_state_t st;
            aan_pkg::aan_lamp_t lamp_d;
            assign st = aan_pkg::aan_port_state_t'(port_state[3*i +: 3]);
            assign is_alarm[i] = (st == aan_pkg::PORT_ALARM);
            assign is_error[i] = (st == aan_pkg::PORT_ERROR);

            // Lamp colour comes only from this port's own state.
            always_comb
            begin
                case (st)
                    aan_pkg::PORT_DISABLED: lamp_d = '{red: 1'b0, green: 1'b0};
                    aan_pkg::PORT_NORMAL: lamp_d = '{red: 1'b0, green: 1'b1};
                    aan_pkg::PORT_SELECTED: lamp_d = '{red: 1'b0, green: blink_q};
                    aan_pkg::PORT_ALARM: lamp_d = '{red: 1'b1, green: 1'b0};
                    aan_pkg::PORT_ERROR: lamp_d = '{red: blink_q, green: 1'b0};
                    default: lamp_d = '{red: 1'b0, green: 1'b0};
                endcase
            end

            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                begin
                    lamp_red[i] <= 1'b0;
                    lamp_green[i] <= 1'b0;
                end
                else
                begin
                    lamp_red[i] <= lamp_d.red;
                    lamp_green[i] <= lamp_d.green;
                end
            end

            // Zone activation: self-clearing follows the alarm, latching waits for ack.
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                    zone_act_q[i] <= 1'b0;
                else if (is_alarm[i])
                    zone_act_q[i] <= 1'b1;
                else if (!zone_latch_q[i] || ack_pulse)
                    zone_act_q[i] <= 1'b0;
            end

            // Normally-closed zones invert the coil drive.
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                    zone_relay[i] <= 1'b0;
                else
                    zone_relay[i] <= zone_act_q[i] ^ zone_nc_q[i];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Beeper
    // ------------------------------------------------------------------
    logic any_alarm;
    logic any_error;
    logic muted_q;
    logic beep_ph_q;
    logic [aan_pkg::CNT_W-1:0] beep_cnt_q;

    assign any_alarm = |is_alarm;
    assign any_error = |is_error;

    // Mute holds until the alarm episode ends, so a new alarm beeps again.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            muted_q <= 1'b0;
        else if (!any_alarm)
            muted_q <= 1'b0;
        else if (mute_pulse)
            muted_q <= 1'b1;
    end

    // Phase counter restarts at each episode so the first beep is full length.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || !any_alarm)
        begin
            beep_cnt_q <= '0;
            beep_ph_q <= 1'b1;
        end
        else if (beep_cnt_q == aan_pkg::CNT_W'(BEEP_HALF_CYC - 1))
        begin
            beep_cnt_q <= '0;
            beep_ph_q <= ~beep_ph_q;
        end
        else
        begin
            beep_cnt_q <= beep_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            beeper <= 1'b0;
        else
            beeper <= any_alarm & beep_ph_q & ~muted_q & ctrl_q[aan_pkg::CTRL_BEEP_EN];
    end

    // ------------------------------------------------------------------
    // Master relay
    // ------------------------------------------------------------------
    logic mr_act_q;
    logic mr_trip;

    // Normally-activated mode also trips on a sensor error.
    assign mr_trip = any_alarm | (ctrl_q[aan_pkg::CTRL_MR_NORM_ACT] & any_error);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            mr_act_q <= 1'b0;
        else if (mr_trip)
            mr_act_q <= 1'b1;
        else if (!ctrl_q[aan_pkg::CTRL_MR_LATCH])
            mr_act_q <= 1'b0;
        else if (ack_pulse)
            mr_act_q <= 1'b0;
    end

    // Energised when idle in normally-activated mode; loss of power then trips it.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            master_relay <= 1'b0;
        else
            master_relay <= mr_act_q ^ ctrl_q[aan_pkg::CTRL_MR_NORM_ACT];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            usb_lamp <= 1'b0;
        else
            usb_lamp <= pin_sync_q[2];
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [aan_pkg::IRQ_W-1:0] ev;
    logic [aan_pkg::IRQ_W-1:0] clr;
    logic [1:0] prev_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            prev_q <= 2'h0;
        else
            prev_q <= {any_error, any_alarm};
    end

    always_comb
    begin
        ev = '0;
        ev[aan_pkg::EV_ALARM] = any_alarm & ~prev_q[0];
        ev[aan_pkg::EV_ERROR] = any_error & ~prev_q[1];
        ev[aan_pkg::EV_ACK] = ack_pulse;
    end

    assign clr = (wr_en && ap_q.haddr == aan_pkg::ADDR_IRQ_CLR) ?
        hwdata[aan_pkg::IRQ_W-1:0] : '0;

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            irq_stat_q <= '0;
        else
            irq_stat_q <= (irq_stat_q & ~clr) | ev;
    end

    assign irq = |(irq_stat_q & irq_en_q);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (ap_valid_q && !ap_q.hwrite)
        begin
            case (ap_q.haddr)
                aan_pkg::ADDR_CTRL: hrdata[2:0] = ctrl_q;
                aan_pkg::ADDR_ZONE_NC: hrdata[NUM_PORTS-1:0] = zone_nc_q;
                aan_pkg::ADDR_ZONE_LATCH: hrdata[NUM_PORTS-1:0] = zone_latch_q;
                aan_pkg::ADDR_STATUS:
                begin
                    hrdata[aan_pkg::ST_MR_ACT] = mr_act_q;
                    hrdata[aan_pkg::ST_BEEP] = beeper;
                    hrdata[aan_pkg::ST_MUTED] = muted_q;
                    hrdata[aan_pkg::ST_ANY_ALARM] = any_alarm;
                    hrdata[aan_pkg::ST_ZONE_LSB +: NUM_PORTS] = zone_act_q;
                end
                aan_pkg::ADDR_IRQ_STAT: hrdata[aan_pkg::IRQ_W-1:0] = irq_stat_q;
                aan_pkg::ADDR_IRQ_EN: hrdata[aan_pkg::IRQ_W-1:0] = irq_en_q;
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

endmodule

/* aan_pkg.sv */
package aan_pkg;

    // ------------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 8;
    localparam int CLK_HZ = 10_000_000;
    // Beeper repeat period in milliseconds; the tone is on for half of it.
    localparam int BEEP_PERIOD_MS = 500;
    localparam int BEEP_HALF_CYC = (CLK_HZ / 1000) * BEEP_PERIOD_MS / 2;
    // Lamp blink period in milliseconds, a fixed choice.
    localparam int BLINK_PERIOD_MS = 1000;
    localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ZONE_NC = 8'h04;
    localparam logic [7:0] ADDR_ZONE_LATCH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;

    // CTRL fields.
    localparam int CTRL_MR_NORM_ACT = 0;
    localparam int CTRL_MR_LATCH = 1;
    localparam int CTRL_BEEP_EN = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // STATUS fields.
    localparam int ST_MR_ACT = 0;
    localparam int ST_BEEP = 1;
    localparam int ST_MUTED = 2;
    localparam int ST_ANY_ALARM = 3;
    localparam int ST_ZONE_LSB = 8;

    // Interrupt event bits.
    localparam int IRQ_W = 3;
    localparam int EV_ALARM = 0;
    localparam int EV_ERROR = 1;
    localparam int EV_ACK = 2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PORT_DISABLED = 3'b000,
        PORT_NORMAL = 3'b001,
        PORT_SELECTED = 3'b010,
        PORT_ALARM = 3'b011,
        PORT_ERROR = 3'b100
    } aan_port_state_t;

    typedef struct packed {
        logic red;
        logic green;
    } aan_lamp_t;

    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [7:0] haddr;
    } aan_ahb_addr_t;

endpackage

/* aan_annunciator_props.sv */
`timescale 1ns/1ns
module aan_annunciator_props #(
    parameter int NUM_PORTS = 8,
    parameter int BEEP_HALF_CYC = aan_pkg::BEEP_HALF_CYC,
    parameter int BLINK_HALF_CYC = aan_pkg::BLINK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3*NUM_PORTS-1:0] port_state,
    input wire logic usb_connected,
    input wire logic [NUM_PORTS-1:0] lamp_red,
    input wire logic [NUM_PORTS-1:0] lamp_green,
    input wire logic usb_lamp,
    input wire logic beeper
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic alarm_any;
    int beep_run_q;
    int green_run_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Any port in alarm; the beeper may only sound on the cycle after this.
    always_comb
    begin
        alarm_any = 1'h0;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            alarm_any |= (port_state[3*i +: 3] == aan_pkg::PORT_ALARM);
        end
    end

    // Run lengths are counted because the real periods are far too long to unroll.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            beep_run_q <= 0;
            green_run_q <= 0;
        end
        else
        begin
            beep_run_q <= beeper ? beep_run_q + 1 : 0;
            // Port 2 is the one the bench selects, so this run counter is really exercised.
            if ($past(port_state[8:6]) == aan_pkg::PORT_SELECTED && $stable(lamp_green[2]))
                green_run_q <= green_run_q + 1;
            else
                green_run_q <= 0;
        end
    end

    sequence s_usb_up;
        usb_connected[*5];
    endsequence

    sequence s_usb_down;
        (!usb_connected)[*5];
    endsequence

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Each lamp looks at its own port only.
    for (genvar i = 0; i < NUM_PORTS; i++)
    begin : g_port
        a_lamp_dark: assert property (
            port_state[3*i +: 3] == aan_pkg::PORT_DISABLED |=> !lamp_red[i] && !lamp_green[i])
            else $error("Lamp lit on a disabled port.");
        a_lamp_green: assert property (
            port_state[3*i +: 3] == aan_pkg::PORT_NORMAL |=> lamp_green[i] && !lamp_red[i])
            else $error("Healthy port not steady green.");
        a_lamp_red: assert property (
            port_state[3*i +: 3] == aan_pkg::PORT_ALARM |=> lamp_red[i] && !lamp_green[i])
            else $error("Alarmed port not steady red.");
    end

    a_green_blinks: assert property (green_run_q <= BLINK_HALF_CYC)
        else $error("Selected port lamp stopped blinking.");
    a_beep_bound: assert property (beep_run_q <= BEEP_HALF_CYC)
        else $error("Beeper on longer than half a period.");
    a_beep_cause: assert property (beeper |-> $past(alarm_any))
        else $error("Beeper on without an alarm.");
    a_usb_on: assert property (s_usb_up |-> usb_lamp)
        else $error("USB lamp dark while connected.");
    a_usb_off: assert property (s_usb_down |-> !usb_lamp)
        else $error("USB lamp lit while disconnected.");
endmodule

bind aan_annunciator aan_annunciator_props #(
    .NUM_PORTS(NUM_PORTS),
    .BEEP_HALF_CYC(BEEP_HALF_CYC),
    .BLINK_HALF_CYC(BLINK_HALF_CYC)
) aan_annunciator_props_i (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .port_state(port_state),
    .usb_connected(usb_connected),
    .lamp_red(lamp_red),
    .lamp_green(lamp_green),
    .usb_lamp(usb_lamp),
    .beeper(beeper)
);

/* aan_field_model.sv */
`timescale 1ns/1ns
module aan_field_model (
    input wire logic clk_sys,
    output logic [3*aan_pkg::NUM_PORTS-1:0] port_state,
    output logic key_mute,
    output logic key_ack,
    output logic usb_connected
);
    // Ports start disabled, keys released and no host attached.
    initial
    begin
        port_state = '0;
        key_mute = 1'h0;
        key_ack = 1'h0;
        usb_connected = 1'h0;
    end

    // Sensor evaluation reports a new state for one port just after an edge.
    task automatic set_port(input int idx, input aan_pkg::aan_port_state_t st);
        @(posedge clk_sys);
        port_state[3*idx +: 3] <= st;
    endtask

    // A key is held for several cycles so the block's synchroniser cannot miss it.
    task automatic press(input logic mute);
        @(posedge clk_sys);
        if (mute)
            key_mute <= 1'h1;
        else
            key_ack <= 1'h1;
        repeat (6) @(posedge clk_sys);
        key_mute <= 1'h0;
        key_ack <= 1'h0;
    endtask

    task automatic set_usb(input logic on);
        @(posedge clk_sys);
        usb_connected <= on;
    endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd_smp, rd;
    logic hreadyout, hresp, usb_lamp, beeper, master_relay, irq;
    logic [23:0] port_state;
    logic key_mute, key_ack, usb_connected;
    logic [7:0] lamp_red, lamp_green, zone_relay;
    int fails = 0;
    int samples_checked = 0;

    always #50 clk_sys = ~clk_sys;

    // Short beep and blink counts keep the run brief.
    aan_annunciator #(.BEEP_HALF_CYC(4), .BLINK_HALF_CYC(6)) aan_annunciator_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_state(port_state),
        .key_mute(key_mute), .key_ack(key_ack), .usb_connected(usb_connected),
        .lamp_red(lamp_red), .lamp_green(lamp_green), .usb_lamp(usb_lamp),
        .beeper(beeper), .master_relay(master_relay), .zone_relay(zone_relay), .irq(irq));

    aan_field_model aan_field_model_i (
        .clk_sys(clk_sys), .port_state(port_state), .key_mute(key_mute),
        .key_ack(key_ack), .usb_connected(usb_connected));

    // Read data is taken at the edge that closes the data phase.
    always @(posedge clk_sys) rd_smp <= hrdata;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("Checked %0d, failed %0d.", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    // One single word transfer; the slave's ready decides when each phase ends.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hsize <= 3'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        @(negedge clk_sys);
        rd = rd_smp;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'h0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Over 16 cycles a 50 percent beep of period 8 is high exactly 8 times.
    task automatic beeps(input logic [31:0] exp);
        logic [31:0] cnt;
        cnt = 32'h0000_0000;
        repeat (16)
        begin
            @(negedge clk_sys);
            cnt += 32'(beeper);
        end
        chk(cnt, exp);
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        logic [7:0] og, ag, orr, ar;
        hsize <= 3'h0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'h1;
        rd_chk(aan_pkg::ADDR_CTRL, 32'h0000_0000);
        // The slave never stalls and always answers OKAY.
        chkb(hresp, 1'h0);
        chkb(hreadyout, 1'h1);
        rd_chk(aan_pkg::ADDR_STATUS, 32'h0000_0000);
        ahb(1'h1, 8'h1C, 32'hFFFF_FFFF);
        rd_chk(8'h1C, 32'h0000_0000);
        chk(32'({lamp_red, lamp_green}), 32'h0000_0000);
        ahb(1'h1, aan_pkg::ADDR_CTRL, 32'h0000_0004);
        // Ports 0 to 4 each take a different state, the others are set healthy.
        for (int n = 0; n < 8; n++)
        begin
            aan_field_model_i.set_port(n, n < 5 ? aan_pkg::aan_port_state_t'(3'(n))
                : aan_pkg::PORT_NORMAL);
        end
        settle(3);
        og = 8'h00;
        ag = 8'hFF;
        orr = 8'h00;
        ar = 8'hFF;
        repeat (14)
        begin
            @(negedge clk_sys);
            og |= lamp_green;
            ag &= lamp_green;
            orr |= lamp_red;
            ar &= lamp_red;
        end
        chk(32'(og), 32'h0000_00E6);
        chk(32'(ag), 32'h0000_00E2);
        chk(32'(orr), 32'h0000_0018);
        chk(32'(ar), 32'h0000_0008);
        beeps(32'h0000_0008);
        chkb(master_relay, 1'h1);
        chk(32'(zone_relay), 32'h0000_0008);
        aan_field_model_i.press(1'h1);
        settle(4);
        beeps(32'h0000_0000);
        rd_chk(aan_pkg::ADDR_STATUS, 32'h0000_080D);
        aan_field_model_i.set_port(3, aan_pkg::PORT_NORMAL);
        settle(3);
        chk(32'({master_relay, zone_relay}), 32'h0000_0000);
        // Latching master and zone 0; zone 7 normally closed.
        ahb(1'h1, aan_pkg::ADDR_CTRL, 32'h0000_0006);
        ahb(1'h1, aan_pkg::ADDR_ZONE_LATCH, 32'h0000_0001);
        ahb(1'h1, aan_pkg::ADDR_ZONE_NC, 32'h0000_0080);
        settle(2);
        chk(32'(zone_relay), 32'h0000_0080);
        rd_chk(aan_pkg::ADDR_ZONE_NC, 32'h0000_0080);
        aan_field_model_i.set_port(0, aan_pkg::PORT_ALARM);
        settle(3);
        beeps(32'h0000_0008);
        aan_field_model_i.set_port(0, aan_pkg::PORT_NORMAL);
        settle(3);
        chk(32'({master_relay, zone_relay}), 32'h0000_0181);
        aan_field_model_i.press(1'h0);
        settle(6);
        chk(32'({master_relay, zone_relay}), 32'h0000_0080);
        // Normally activated master, released by the standing error on port 4.
        ahb(1'h1, aan_pkg::ADDR_CTRL, 32'h0000_0001);
        settle(3);
        chkb(master_relay, 1'h0);
        aan_field_model_i.set_port(4, aan_pkg::PORT_NORMAL);
        settle(3);
        chkb(master_relay, 1'h1);
        aan_field_model_i.set_port(2, aan_pkg::PORT_ALARM);
        settle(3);
        chk(32'({master_relay, zone_relay}), 32'h0000_0084);
        aan_field_model_i.set_port(2, aan_pkg::PORT_NORMAL);
        settle(3);
        chkb(master_relay, 1'h1);
        aan_field_model_i.set_usb(1'h1);
        settle(6);
        chkb(usb_lamp, 1'h1);
        aan_field_model_i.set_usb(1'h0);
        settle(6);
        chkb(usb_lamp, 1'h0);
        // Alarm, error and acknowledge events are all pending by now.
        rd_chk(aan_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
        chkb(irq, 1'h0);
        ahb(1'h1, aan_pkg::ADDR_IRQ_EN, 32'h0000_0002);
        settle(1);
        chkb(irq, 1'h1);
        rd_chk(aan_pkg::ADDR_IRQ_EN, 32'h0000_0002);
        ahb(1'h1, aan_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
        rd_chk(aan_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        chkb(irq, 1'h0);
        give_verdict();
    end

    // The tests need well under a thousand cycles; twenty thousand means a hang.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
endmodule
